// >>> core/timer_xfer_pkg.sv
// Package: opcodes, field positions and reset values for the timer transfer group
package timer_xfer_pkg;
	localparam int OP_W = 10;
	localparam int NIB_W = 4;
	localparam int BYTE_W = 8;
	localparam int HI_LSB = 4;
	localparam logic [9:0] OP_LOAD_FIRST_ALT = 10'h292;
	localparam logic [9:0] OP_COPY_FIRST_PRI = 10'h2A7;
	localparam logic [9:0] OP_LOAD_FIRST_BOTH = 10'h230;
	localparam logic [9:0] OP_LOAD_SECOND_BOTH = 10'h231;
	localparam logic [9:0] OP_LOAD_SECOND_ALT = 10'h294;
	localparam logic [9:0] OP_COPY_SECOND_PRI = 10'h295;
	localparam logic [7:0] RELOAD_RST = 8'h00;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_FIRST_ALT = 3'h1,
		OP_FIRST_COPY = 3'h3,
		OP_FIRST_BOTH = 3'h2,
		OP_SECOND_BOTH = 3'h6,
		OP_SECOND_ALT = 3'h7,
		OP_SECOND_COPY = 3'h5
	} xfer_op_t;

	typedef struct packed {
		logic load_cnt1;
		logic [7:0] cnt1_val;
		logic load_cnt2;
		logic [7:0] cnt2_val;
	} cnt_load_t;
endpackage

// >>> core/timer_xfer_decode.sv
// Decoder: maps a 10-bit instruction word onto one transfer operation
module timer_xfer_decode
	import timer_xfer_pkg::*;
(
	// Instruction
	input wire logic [9:0] instr,
	input wire logic instr_valid,
	// Decoded operation
	output xfer_op_t op
);
	wire xfer_op_t raw_op;

	// All encodings are one word; execution takes the single cycle that the word is valid
	assign raw_op = (instr == OP_LOAD_FIRST_ALT) ? OP_FIRST_ALT :
		(instr == OP_COPY_FIRST_PRI) ? OP_FIRST_COPY :
		(instr == OP_LOAD_FIRST_BOTH) ? OP_FIRST_BOTH :
		(instr == OP_LOAD_SECOND_BOTH) ? OP_SECOND_BOTH :
		(instr == OP_LOAD_SECOND_ALT) ? OP_SECOND_ALT :
		(instr == OP_COPY_SECOND_PRI) ? OP_SECOND_COPY :
		OP_NONE;
	assign op = instr_valid ? raw_op : OP_NONE;
endmodule

// >>> core/timer_reload_transfer_ops.sv
// Execution of the timer reload and counter transfer instructions
// Overview of operation
// - Loading the first timer's alternate reload puts B in its high nibble and A in its low nibble.
// - Word 292h is decoded as the first timer alternate reload load, one word and one cycle.
// - Word 2A7h copies all 8 bits of the first primary reload into the first counter.
// - Word 231h writes B into the high nibble of the second counter and second primary reload.
// - The same word writes A into the low nibble of both the second counter and primary reload.
// - Word 294h loads the second alternate reload with B high and A low, counter untouched.
// - An instruction copies the second primary reload into the second counter.
// - Word 295h is that copy, 8 bits, one cycle, no carry change and no skip.
module timer_reload_transfer_ops
	import timer_xfer_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Instruction from the decoder stage
	input wire logic [9:0] instr,
	input wire logic instr_valid,
	// Datapath sources
	input wire logic [3:0] acc,
	input wire logic [3:0] reg_b,
	// Counter load requests to the timers
	output cnt_load_t cnt_load,
	// Reload register contents
	output logic [7:0] first_timer_primary_reload,
	output logic [7:0] first_timer_alt_reload,
	output logic [7:0] second_timer_primary_reload,
	output logic [7:0] second_timer_alt_reload,
	// Flag side effects
	output logic carry_we,
	output logic skip_next
);
	////////////////////////////////////////////////////////////////////////////////
	// Decoded operation and the byte that every load instruction moves
	wire xfer_op_t op;
	wire logic [7:0] ba_word;
	wire logic do_first_alt;
	wire logic do_first_copy;
	wire logic do_first_both;
	wire logic do_second_both;
	wire logic do_second_alt;
	wire logic do_second_copy;
	logic [7:0] first_pri_r;
	logic [7:0] first_alt_r;
	logic [7:0] second_pri_r;
	logic [7:0] second_alt_r;
	cnt_load_t load_r;
	cnt_load_t load_nxt;

	timer_xfer_decode u_dec (
		.instr(instr),
		.instr_valid(instr_valid),
		.op(op)
	);

	// One compare per operation keeps every write enable a single named wire
	assign do_first_alt = (op == OP_FIRST_ALT);
	assign do_first_copy = (op == OP_FIRST_COPY);
	assign do_first_both = (op == OP_FIRST_BOTH);
	assign do_second_both = (op == OP_SECOND_BOTH);
	assign do_second_alt = (op == OP_SECOND_ALT);
	assign do_second_copy = (op == OP_SECOND_COPY);

	// B always lands in the high nibble, A in the low one
	assign ba_word = {reg_b, acc};

	////////////////////////////////////////////////////////////////////////////////
	// Reload registers; each holds its value until its own load word comes
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			first_pri_r <= RELOAD_RST;
		else if (do_first_both)
			first_pri_r <= ba_word;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			first_alt_r <= RELOAD_RST;
		else if (do_first_alt)
			first_alt_r <= ba_word;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			second_pri_r <= RELOAD_RST;
		else if (do_second_both)
			second_pri_r <= ba_word;
	end

	// The counter is not touched by this load; only the alternate value changes
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			second_alt_r <= RELOAD_RST;
		else if (do_second_alt)
			second_alt_r <= ba_word;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Counter load strobes; a copy reads the register as it stands this cycle,
	// so a load in the cycle before is already visible to it
	always_comb
	begin
		load_nxt = '0;
		load_nxt.load_cnt1 = do_first_copy || do_first_both;
		load_nxt.cnt1_val = do_first_copy ? first_pri_r : ba_word;
		load_nxt.load_cnt2 = do_second_copy || do_second_both;
		load_nxt.cnt2_val = do_second_copy ? second_pri_r : ba_word;
	end

	// Registered so the timers see a clean one-cycle request with its value
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			load_r <= '0;
		else
			load_r <= load_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign cnt_load = load_r;
	assign first_timer_primary_reload = first_pri_r;
	assign first_timer_alt_reload = first_alt_r;
	assign second_timer_primary_reload = second_pri_r;
	assign second_timer_alt_reload = second_alt_r;
	// None of this group touches carry or skips
	assign carry_we = 1'b0;
	assign skip_next = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Loads of the alternate and primary registers
	first_alt_load_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(instr_valid && instr == OP_LOAD_FIRST_ALT) |=>
		(first_alt_r == $past(ba_word)))
		else $error("first alternate reload not loaded");
	first_alt_decode_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		!(instr_valid && instr == OP_LOAD_FIRST_ALT) |=>
		(first_alt_r == $past(first_alt_r)))
		else $error("first alternate reload changed on other word");
	first_alt_quiet_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(instr_valid && instr == OP_LOAD_FIRST_ALT) |=>
		(!cnt_load.load_cnt1 && !cnt_load.load_cnt2))
		else $error("first alternate load raised a counter strobe");
	first_pri_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		!(instr_valid && instr == OP_LOAD_FIRST_BOTH) |=>
		(first_pri_r == $past(first_pri_r)))
		else $error("first primary reload changed on other word");
	second_both_hi_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(instr_valid && instr == OP_LOAD_SECOND_BOTH) |=>
		(second_pri_r[7:4] == $past(reg_b) && cnt_load.load_cnt2 &&
		cnt_load.cnt2_val[7:4] == $past(reg_b)))
		else $error("second load high nibble wrong");
	second_both_lo_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(instr_valid && instr == OP_LOAD_SECOND_BOTH) |=>
		(second_pri_r[3:0] == $past(acc) &&
		cnt_load.cnt2_val[3:0] == $past(acc)))
		else $error("second load low nibble wrong");
	second_pri_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		!(instr_valid && instr == OP_LOAD_SECOND_BOTH) |=>
		(second_pri_r == $past(second_pri_r)))
		else $error("second primary reload changed on other word");
	second_alt_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(instr_valid && instr == OP_LOAD_SECOND_ALT) |=>
		(second_alt_r == $past(ba_word) && !cnt_load.load_cnt2))
		else $error("second alternate reload wrong");
	second_alt_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		!(instr_valid && instr == OP_LOAD_SECOND_ALT) |=>
		(second_alt_r == $past(second_alt_r)))
		else $error("second alternate reload changed on other word");

	////////////////////////////////////////////////////////////////////////////////
	// Counter copies and strobe sources
	first_copy_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(instr_valid && instr == OP_COPY_FIRST_PRI) |=>
		(cnt_load.load_cnt1 && cnt_load.cnt1_val == $past(first_pri_r)))
		else $error("first counter copy wrong");
	first_strobe_src_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		cnt_load.load_cnt1 |-> ($past(instr_valid) &&
		($past(instr) == OP_COPY_FIRST_PRI || $past(instr) == OP_LOAD_FIRST_BOTH)))
		else $error("first counter strobe without its word");
	second_copy_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(instr_valid && instr == OP_COPY_SECOND_PRI) |=>
		(cnt_load.load_cnt2 && cnt_load.cnt2_val == $past(second_pri_r)))
		else $error("second counter copy wrong");
	second_strobe_src_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		cnt_load.load_cnt2 |-> ($past(instr_valid) &&
		($past(instr) == OP_COPY_SECOND_PRI || $past(instr) == OP_LOAD_SECOND_BOTH)))
		else $error("second counter strobe without its word");
	refused_strobes_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		!instr_valid |=> (!cnt_load.load_cnt1 && !cnt_load.load_cnt2))
		else $error("counter strobe with no valid word");
	no_flag_effect_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(instr_valid && instr == OP_COPY_SECOND_PRI) |-> (!carry_we && !skip_next) ##1
		(second_pri_r == $past(second_pri_r)))
		else $error("second copy disturbed flags or reload");
endmodule

// >>> verification/timer_reload_transfer_ops_tb.sv
// Self-checking bench for the timer reload transfer group
module timer_reload_transfer_ops_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import timer_xfer_pkg::*;
	typedef struct packed {cnt_load_t c; logic [7:0] p1, a1, p2, a2;} note_t;
	logic ref_clk, rstn, instr_valid, carry_we, skip_next;
	logic [9:0] instr;
	logic [3:0] acc, reg_b;
	cnt_load_t cnt_load;
	logic [7:0] p1, a1, p2, a2;
	logic [15:0] seed;
	logic [9:0] ops [0:5] = '{OP_LOAD_FIRST_ALT, OP_COPY_FIRST_PRI, OP_LOAD_FIRST_BOTH,
		OP_LOAD_SECOND_BOTH, OP_LOAD_SECOND_ALT, OP_COPY_SECOND_PRI};
	note_t m, w;
	note_t notes [$];
	int n_errors = 0, compares = 0, cycles = 0;
	timer_reload_transfer_ops uut (.ref_clk(ref_clk), .rstn(rstn), .instr(instr),
		.instr_valid(instr_valid), .acc(acc), .reg_b(reg_b), .cnt_load(cnt_load),
		.first_timer_primary_reload(p1), .first_timer_alt_reload(a1),
		.second_timer_primary_reload(p2), .second_timer_alt_reload(a2),
		.carry_we(carry_we), .skip_next(skip_next));
	////////////////////////////////////////////////////////////////////////////////
	// Eight shifts per call so consecutive draws are not simple shifts of each other
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		for (int k = 0; k < 8; k++)
			s = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
		return s;
	endfunction
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
		compares++;
		if (s !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic s);
		compares++;
		if (s !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %b seen %b", nm, e, s);
		end
	endtask
	task print_verdict();
		if (n_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Notes the effect of the word the design samples at this edge; copies see new loads
	task automatic step();
		if (instr_valid)
			case (instr)
				OP_LOAD_FIRST_ALT: m.a1 = {reg_b, acc};
				OP_LOAD_FIRST_BOTH: m.p1 = {reg_b, acc};
				OP_LOAD_SECOND_BOTH: m.p2 = {reg_b, acc};
				OP_LOAD_SECOND_ALT: m.a2 = {reg_b, acc};
				default: ;
			endcase
		m.c.load_cnt1 = instr_valid && (instr == OP_COPY_FIRST_PRI || instr == OP_LOAD_FIRST_BOTH);
		m.c.cnt1_val = m.p1;
		m.c.load_cnt2 = instr_valid && (instr == OP_COPY_SECOND_PRI || instr == OP_LOAD_SECOND_BOTH);
		m.c.cnt2_val = m.p2;
		notes.push_back(m);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial
	begin
		{rstn, instr_valid, instr, acc, reg_b} = '0;
		m = '0;
		seed = 16'hA121;
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		for (int i = 0; i < 3000; i++)
		begin
			@(posedge ref_clk);
			step();
			seed = lfsr(seed);
			instr <= (seed[2:0] < 3'h6) ? ops[seed[2:0]] : seed[15:6];
			instr_valid <= seed[5:3] != 3'h0;
			seed = lfsr(seed);
			{reg_b, acc} <= seed[7:0];
		end
		repeat (2) @(negedge ref_clk);
		print_verdict();
	end
	always @(negedge ref_clk)
		if (notes.size() > 0)
		begin
			w = notes.pop_front();
			chk1("load_cnt1", w.c.load_cnt1, cnt_load.load_cnt1);
			if (w.c.load_cnt1) chk8("cnt1_val", w.c.cnt1_val, cnt_load.cnt1_val);
			chk1("load_cnt2", w.c.load_cnt2, cnt_load.load_cnt2);
			if (w.c.load_cnt2) chk8("cnt2_val", w.c.cnt2_val, cnt_load.cnt2_val);
			chk8("first_primary", w.p1, p1);
			chk8("first_alt", w.a1, a1);
			chk8("second_primary", w.p2, p2);
			chk8("second_alt", w.a2, a2);
			chk1("carry_we", 1'b0, carry_we);
			chk1("skip_next", 1'b0, skip_next);
		end
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_errors++;
			print_verdict();
		end
	end
endmodule
